// *** hdl/spdq_map.svh ***
// offsets, field positions, reset values and timing counts of the set-point and dq reference registers
`ifndef SPDQ_MAP_SVH
`define SPDQ_MAP_SVH

// ----------------------------------------------------------------
// mode-register addresses
// ----------------------------------------------------------------
`define SPDQ_ADDR_SPC 6'h0D
`define SPDQ_ADDR_DQR 6'h0E

// ----------------------------------------------------------------
// set_point_control field positions
// ----------------------------------------------------------------
`define SPDQ_SPC_TRAIN 0
`define SPDQ_SPC_PREAMBLE 1
`define SPDQ_SPC_MONOUT 2
`define SPDQ_SPC_HICUR 3
`define SPDQ_SPC_RATEOPT 4
`define SPDQ_SPC_MASKOFF 5
`define SPDQ_SPC_WSP 6
`define SPDQ_SPC_OSP 7
`define SPDQ_SPC_RST 8'h00

// ----------------------------------------------------------------
// dq_reference_level fields and reset values
// ----------------------------------------------------------------
`define SPDQ_DQR_RANGE 6
`define SPDQ_DQR_CODE_MAX 6'h32
`define SPDQ_DQR_CODE_RST 6'h0D
`define SPDQ_DQR_RANGE_RST 1'h1

// ----------------------------------------------------------------
// refresh-rate status codes
// ----------------------------------------------------------------
`define SPDQ_RRS_C1 3'h1
`define SPDQ_RRS_C2 3'h2
`define SPDQ_RRS_C3 3'h3

// ----------------------------------------------------------------
// timing: mode-register read answer follows the command by one cycle
// ----------------------------------------------------------------
`define SPDQ_RD_LAT 1

`endif

// *** hdl/spdq_pkg.sv ***
// types shared by both ends of the set-point and dq reference link
package spdq_pkg;

  // one set-point copy of the dq reference register
  typedef struct packed {
    logic range;
    logic [5:0] code;
  } spdq_vref_t;

  // controller sequencing states, one-hot
  typedef enum logic [3:0] {
    SPDQ_IDLE  = 4'h1,
    SPDQ_CKEUP = 4'h2,
    SPDQ_SENT  = 4'h4,
    SPDQ_WAIT  = 4'h8
  } spdq_state_t;

endpackage : spdq_pkg

// *** hdl/spdq_if.sv ***
// command/address and data link between the controller and the device
`timescale 1ns/100ps
interface spdq_if (
  input wire logic MCLK
);
  logic cke;
  logic cmd_valid;
  logic cmd_write;
  logic [5:0] cmd_addr;
  logic [7:0] cmd_op;
  logic [5:0] ca;
  logic rd_valid;
  logic [7:0] dq;
  logic dq_oe;

  modport dev (
    input cke, cmd_valid, cmd_write, cmd_addr, cmd_op, ca,
    output rd_valid, dq, dq_oe
  );
  modport ctl (
    output cke, cmd_valid, cmd_write, cmd_addr, cmd_op, ca,
    input rd_valid, dq, dq_oe
  );
endinterface : spdq_if

// *** hdl/spdq_dev.sv ***
// device end: set_point_control and set-point-banked dq_reference_level registers
`timescale 1ns/100ps
`include "spdq_map.svh"
module spdq_dev #(
  parameter int CA_W = 6
) (
  spdq_if.dev LNK,
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic DEV_FEATURE_RATEOPT,
  input wire logic [2:0] REFRESH_RAW,
  input wire spdq_pkg::spdq_vref_t CA_VREF_ACTIVE,
  output logic CMD_TRAIN_MODE,
  output logic RPRE_TRAIN,
  output logic VREF_HIGH_CURRENT,
  output logic DATA_MASK_OFF,
  output logic WR_SET_POINT,
  output logic OP_SET_POINT,
  output spdq_pkg::spdq_vref_t DQ_VREF_ACTIVE,
  output logic [2:0] REFRESH_STATUS,
  output logic VREF_MON_EN,
  output spdq_pkg::spdq_vref_t VREF_MON_DQ0,
  output spdq_pkg::spdq_vref_t VREF_MON_DQ1
);
  import spdq_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the echo takes its bits from the 6-bit ca lines, so wider is impossible
  if (CA_W < 1 || CA_W > 6) begin : g_bad_ca
    $error("CA_W must fit the 6-bit ca bus");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] spc_q;
  spdq_vref_t vref_q [2];
  logic train_hold;
  logic cmd_go;
  logic wr_spc;
  logic wr_dqr;
  logic rd_go;
  logic code_ok;
  logic [7:0] rd_data;
  logic rd_valid_q;
  logic [7:0] dq_q;
  logic dq_oe_q;
  spdq_vref_t active_q;
  logic [2:0] rrs_q;
  logic mon_q;
  spdq_vref_t mon0_q;
  spdq_vref_t mon1_q;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // training with CKE low turns the command bus into a sampling bus
  assign train_hold = spc_q[`SPDQ_SPC_TRAIN] && !LNK.cke;
  assign cmd_go = LNK.cmd_valid && !train_hold;
  // address decoding of the two mapped registers
  always_comb begin
    wr_spc = 1'b0;
    wr_dqr = 1'b0;
    if (cmd_go && LNK.cmd_write && LNK.cmd_addr == `SPDQ_ADDR_SPC) begin
      wr_spc = 1'b1;
    end else if (cmd_go && LNK.cmd_write && LNK.cmd_addr == `SPDQ_ADDR_DQR) begin
      wr_dqr = 1'b1;
    end
  end
  assign rd_go = cmd_go && !LNK.cmd_write;
  // reserved codes are refused whole so a stray code never lands in a copy
  assign code_ok = LNK.cmd_op[5:0] <= `SPDQ_DQR_CODE_MAX;

  // ----------------------------------------------------------------
  // set_point_control register
  // ----------------------------------------------------------------
  // one write updates every control bit at once
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      spc_q <= `SPDQ_SPC_RST;
    end else if (wr_spc) begin
      spc_q <= LNK.cmd_op;
    end
  end

  // ----------------------------------------------------------------
  // dq_reference_level, one copy per set point
  // ----------------------------------------------------------------
  // only the copy chosen by the write selector changes; the operating copy
  // is undisturbed when the other one is rewritten
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      vref_q[0] <= '{range: `SPDQ_DQR_RANGE_RST, code: `SPDQ_DQR_CODE_RST};
      vref_q[1] <= '{range: `SPDQ_DQR_RANGE_RST, code: `SPDQ_DQR_CODE_RST};
    end else if (wr_dqr && code_ok) begin
      // range and code always travel together; bit7 is dropped
      vref_q[spc_q[`SPDQ_SPC_WSP]] <= '{range: LNK.cmd_op[`SPDQ_DQR_RANGE], code: LNK.cmd_op[5:0]};
    end
  end

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  // the control register is write-only and every other address reads zero
  always_comb begin
    rd_data = 8'h00;
    if (LNK.cmd_addr == `SPDQ_ADDR_DQR) begin
      rd_data = {1'b0, vref_q[spc_q[`SPDQ_SPC_WSP]]};
    end
  end

  // ----------------------------------------------------------------
  // dq bus driver
  // ----------------------------------------------------------------
  // training echo has priority: commands are ignored meanwhile
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rd_valid_q <= 1'b0;
      dq_q <= 8'h00;
      dq_oe_q <= 1'b0;
    end else if (train_hold) begin
      rd_valid_q <= 1'b0;
      dq_q <= {{(8 - CA_W){1'b0}}, LNK.ca[CA_W-1:0]};
      dq_oe_q <= 1'b1;
    end else if (rd_go) begin
      rd_valid_q <= 1'b1;
      dq_q <= rd_data;
      dq_oe_q <= 1'b1;
    end else begin
      rd_valid_q <= 1'b0;
      dq_q <= 8'h00;
      dq_oe_q <= 1'b0;
    end
  end
  assign LNK.rd_valid = rd_valid_q;
  assign LNK.dq = dq_q;
  assign LNK.dq_oe = dq_oe_q;

  // ----------------------------------------------------------------
  // operating copy
  // ----------------------------------------------------------------
  // registered so the output comes from a flop; follows a change one cycle late
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      active_q <= '{range: `SPDQ_DQR_RANGE_RST, code: `SPDQ_DQR_CODE_RST};
    end else begin
      active_q <= vref_q[spc_q[`SPDQ_SPC_OSP]];
    end
  end

  // ----------------------------------------------------------------
  // refresh-rate status filter
  // ----------------------------------------------------------------
  // with the device feature present and the option off, the two fine codes fold into the next code
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rrs_q <= 3'h0;
    end else if (DEV_FEATURE_RATEOPT && !spc_q[`SPDQ_SPC_RATEOPT] &&
                 (REFRESH_RAW == `SPDQ_RRS_C1 || REFRESH_RAW == `SPDQ_RRS_C2)) begin
      rrs_q <= `SPDQ_RRS_C3;
    end else begin
      rrs_q <= REFRESH_RAW;
    end
  end

  // ----------------------------------------------------------------
  // reference monitor output
  // ----------------------------------------------------------------
  // only the active set point is ever shown; idle monitors read zero
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      mon_q <= 1'b0;
      mon0_q <= '0;
      mon1_q <= '0;
    end else begin
      mon_q <= spc_q[`SPDQ_SPC_MONOUT];
      mon0_q <= spc_q[`SPDQ_SPC_MONOUT] ? CA_VREF_ACTIVE : '0;
      mon1_q <= spc_q[`SPDQ_SPC_MONOUT] ? vref_q[spc_q[`SPDQ_SPC_OSP]] : '0;
    end
  end

  // ----------------------------------------------------------------
  // mode outputs straight from the control register, then the registered reference, status and monitor outputs
  // ----------------------------------------------------------------
  assign CMD_TRAIN_MODE = spc_q[`SPDQ_SPC_TRAIN];
  assign RPRE_TRAIN = spc_q[`SPDQ_SPC_PREAMBLE];
  assign VREF_HIGH_CURRENT = spc_q[`SPDQ_SPC_HICUR];
  assign DATA_MASK_OFF = spc_q[`SPDQ_SPC_MASKOFF];
  assign WR_SET_POINT = spc_q[`SPDQ_SPC_WSP];
  assign OP_SET_POINT = spc_q[`SPDQ_SPC_OSP];
  assign DQ_VREF_ACTIVE = active_q;
  assign REFRESH_STATUS = rrs_q;
  assign VREF_MON_EN = mon_q;
  assign VREF_MON_DQ0 = mon0_q;
  assign VREF_MON_DQ1 = mon1_q;

endmodule : spdq_dev

// *** hdl/spdq_ctl.sv ***
// controller end: issues mode-register reads and writes and keeps its side of the link
`timescale 1ns/100ps
`include "spdq_map.svh"
module spdq_ctl (
  spdq_if.ctl LNK,
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [5:0] REQ_ADDR,
  input wire logic [7:0] REQ_DATA,
  input wire logic CKE_LOW,
  input wire logic [5:0] TRAIN_CA,
  input wire logic [2:0] REFRESH_REPORTED,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic MASKED_WRITE_OK,
  output logic [2:0] REFRESH_MODE
);
  import spdq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spdq_state_t state_q;
  logic [7:0] spc_q;
  logic cke_q;
  logic valid_q;
  logic write_q;
  logic [5:0] addr_q;
  logic [7:0] op_q;
  logic [5:0] ca_q;
  logic ready_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic [2:0] mode_q;
  logic mask_ok_q;
  logic accept;
  logic [7:0] op_in;

  assign accept = ready_q && REQ_VALID;
  // reference writes always carry range with code, reserved bit cleared
  assign op_in = (REQ_ADDR == `SPDQ_ADDR_DQR) ? {1'b0, REQ_DATA[6:0]} : REQ_DATA;

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  // during training with CKE low the device ignores commands, so CKE is
  // raised one cycle ahead; this covers the write that ends training
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state_q <= SPDQ_IDLE;
      cke_q <= 1'b1;
      valid_q <= 1'b0;
      write_q <= 1'b0;
      addr_q <= 6'h00;
      op_q <= 8'h00;
      ready_q <= 1'b1;
    end else begin
      case (state_q)
        SPDQ_IDLE: begin
          if (accept) begin
            write_q <= REQ_WRITE;
            addr_q <= REQ_ADDR;
            op_q <= op_in;
            ready_q <= 1'b0;
            if (spc_q[`SPDQ_SPC_TRAIN] && !cke_q) begin
              cke_q <= 1'b1;
              state_q <= SPDQ_CKEUP;
            end else begin
              valid_q <= 1'b1;
              state_q <= SPDQ_SENT;
            end
          end else begin
            cke_q <= !CKE_LOW;
          end
        end
        SPDQ_CKEUP: begin
          valid_q <= 1'b1;
          state_q <= SPDQ_SENT;
        end
        SPDQ_SENT: begin
          valid_q <= 1'b0;
          ready_q <= write_q;
          state_q <= write_q ? SPDQ_IDLE : SPDQ_WAIT;
        end
        SPDQ_WAIT: begin
          ready_q <= 1'b1;
          state_q <= SPDQ_IDLE;
        end
        default: begin
          state_q <= SPDQ_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shadow of the write-only control register
  // ----------------------------------------------------------------
  // masked-write permission kept in its own flop so the output needs no gate
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      spc_q <= `SPDQ_SPC_RST;
      mask_ok_q <= 1'b1;
    end else if (state_q == SPDQ_SENT && write_q && addr_q == `SPDQ_ADDR_SPC) begin
      spc_q <= op_q;
      mask_ok_q <= !op_q[`SPDQ_SPC_MASKOFF];
    end
  end

  // ----------------------------------------------------------------
  // read answer, training pattern, user status
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
      ca_q <= 6'h00;
      mode_q <= 3'h0;
    end else begin
      rsp_valid_q <= state_q == SPDQ_WAIT && LNK.rd_valid;
      if (state_q == SPDQ_WAIT && LNK.rd_valid) begin
        rsp_data_q <= LNK.dq;
      end
      ca_q <= TRAIN_CA;
      mode_q <= REFRESH_REPORTED;
    end
  end

  assign LNK.cke = cke_q;
  assign LNK.cmd_valid = valid_q;
  assign LNK.cmd_write = write_q;
  assign LNK.cmd_addr = addr_q;
  assign LNK.cmd_op = op_q;
  assign LNK.ca = ca_q;
  assign REQ_READY = ready_q;
  assign RSP_VALID = rsp_valid_q;
  assign RSP_DATA = rsp_data_q;
  assign MASKED_WRITE_OK = mask_ok_q;
  assign REFRESH_MODE = mode_q;

endmodule : spdq_ctl

// *** verification/spdq_monitor.sv ***
// link-level assertions for the set-point and dq reference link
`timescale 1ns/100ps
`include "spdq_map.svh"
module spdq_monitor (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic cke,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [5:0] cmd_addr,
  input wire logic [7:0] cmd_op,
  input wire logic [5:0] ca,
  input wire logic rd_valid,
  input wire logic [7:0] dq,
  input wire logic dq_oe
);
  logic train_q;

  default clocking mon_cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  // shadow of the training bit; a write taken while training with cke low is dropped, as the device does
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      train_q <= 1'b0;
    end else if (cmd_valid && cmd_write && cmd_addr == `SPDQ_ADDR_SPC && !(train_q && !cke)) begin
      train_q <= cmd_op[`SPDQ_SPC_TRAIN];
    end
  end

  // ----------------------------------------------------------------
  // read answers and training echo
  // ----------------------------------------------------------------
  AST_RD_ANSWER: assert property (cmd_valid && !cmd_write && cke |=> rd_valid && dq_oe)
    else $error("read command got no answer one cycle later");
  AST_RD_CAUSE: assert property (rd_valid |-> $past(cmd_valid && !cmd_write))
    else $error("read answer without a read command");
  AST_SPC_READS_ZERO: assert property (rd_valid && $past(cmd_addr) != `SPDQ_ADDR_DQR |-> dq == 8'h00)
    else $error("control or unmapped read returned nonzero data");
  AST_DQR_CODE_LIMIT: assert property (rd_valid && $past(cmd_addr) == `SPDQ_ADDR_DQR
    |-> dq[5:0] <= `SPDQ_DQR_CODE_MAX)
    else $error("dq reference read shows a reserved code");
  AST_DQR_RSV_READ: assert property (rd_valid && $past(cmd_addr) == `SPDQ_ADDR_DQR |-> !dq[7])
    else $error("dq reference read shows bit 7 set");
  AST_OP7_SENT_ZERO: assert property (cmd_valid && cmd_write && cmd_addr == `SPDQ_ADDR_DQR |-> !cmd_op[7])
    else $error("dq reference write carries bit 7 set");
  AST_TRAIN_ECHO: assert property (train_q && !cke && $past(train_q && !cke)
    |-> dq_oe && !rd_valid && dq == {2'h0, $past(ca)})
    else $error("training echo of ca missing on dq");
  AST_CKE_BEFORE_CMD: assert property (cmd_valid && train_q |-> cke)
    else $error("command sent while training with cke low");
endmodule : spdq_monitor

// *** verification/set_point_and_dq_vref_mode_regs_bench.sv ***
// self-checking bench joining controller and device ends of the mode-register link
`timescale 1ns/100ps
`include "spdq_map.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module set_point_and_dq_vref_mode_regs_bench;
  import spdq_pkg::*;
  logic mclk, rst_n, req_valid, req_write, cke_low, feat_opt, req_ready, rsp_valid, masked_ok;
  logic cmd_train, rpre, vhc, mask_off, wsp, osp, mon_en;
  logic [5:0] req_addr, train_ca, flags;
  logic [7:0] req_data, rsp_data, rdat;
  logic [2:0] refresh_raw, refresh_status, refresh_mode;
  spdq_vref_t ca_vref, dq_active, mon_dq0, mon_dq1;
  spdq_vref_t cp [2];
  int num_errors = 0;
  int n_compared = 0;
  int seed = 32'h9564c889;

  spdq_if lnk (.MCLK(mclk));
  spdq_dev u_spdq_dev (.LNK(lnk), .MCLK(mclk), .RST_N(rst_n), .DEV_FEATURE_RATEOPT(feat_opt),
    .REFRESH_RAW(refresh_raw), .CA_VREF_ACTIVE(ca_vref), .CMD_TRAIN_MODE(cmd_train), .RPRE_TRAIN(rpre),
    .VREF_HIGH_CURRENT(vhc), .DATA_MASK_OFF(mask_off), .WR_SET_POINT(wsp), .OP_SET_POINT(osp),
    .DQ_VREF_ACTIVE(dq_active), .REFRESH_STATUS(refresh_status), .VREF_MON_EN(mon_en),
    .VREF_MON_DQ0(mon_dq0), .VREF_MON_DQ1(mon_dq1));
  spdq_ctl u_spdq_ctl (.LNK(lnk), .MCLK(mclk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
    .REQ_ADDR(req_addr), .REQ_DATA(req_data), .CKE_LOW(cke_low), .TRAIN_CA(train_ca),
    .REFRESH_REPORTED(refresh_status), .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .MASKED_WRITE_OK(masked_ok), .REFRESH_MODE(refresh_mode));
  spdq_monitor u_spdq_monitor (.MCLK(mclk), .RST_N(rst_n), .cke(lnk.cke), .cmd_valid(lnk.cmd_valid),
    .cmd_write(lnk.cmd_write), .cmd_addr(lnk.cmd_addr), .cmd_op(lnk.cmd_op), .ca(lnk.ca),
    .rd_valid(lnk.rd_valid), .dq(lnk.dq), .dq_oe(lnk.dq_oe));

  // control outputs in register bit order 7,6,5,3,1,0
  assign flags = {osp, wsp, mask_off, vhc, rpre, cmd_train};

  // ----------------------------------------------------------------
  // expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [2:0] exp_refresh(input logic [2:0] raw, input logic opt, input logic feat);
    return (feat && !opt && (raw == `SPDQ_RRS_C1 || raw == `SPDQ_RRS_C2)) ? `SPDQ_RRS_C3 : raw;
  endfunction : exp_refresh

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // one request held until taken, then waits for ready again; read data lands in rdat
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_data <= d;
    do begin @(posedge mclk); n++; end while (req_ready !== 1'b1 && n < 20);
    req_valid <= 1'b0;
    do begin @(posedge mclk); n++; end while (req_ready !== 1'b1 && n < 40);
    `CHK(n < 40, 1'b1)
    // the answer pulse stands in the very cycle in which ready returns after a read
    `CHK(rsp_valid, !wr)
    rdat = rsp_data;
  endtask : xfer

  // synchronous reset held for three edges; model copies return to default
  task automatic do_reset();
    rst_n <= 1'b0;
    tick(3);
    rst_n <= 1'b1;
    cp[0] = {`SPDQ_DQR_RANGE_RST, `SPDQ_DQR_CODE_RST};
    cp[1] = cp[0];
  endtask : do_reset

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // the run needs under four hundred cycles; this is more than seventy times that
  initial begin
    #300000;
    num_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [7:0] d;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 6'h00;
    req_data = 8'h00;
    cke_low = 1'b0;
    train_ca = 6'h00;
    feat_opt = 1'b0;
    refresh_raw = 3'h0;
    ca_vref = 7'($random(seed));
    do_reset();
    xfer(1'b0, `SPDQ_ADDR_DQR, 8'h00);
    `CHK(rdat, 8'h4D)
    `CHK(flags, 6'h00)
    xfer(1'b0, `SPDQ_ADDR_SPC, 8'h00);
    `CHK(rdat, 8'h00)
    xfer(1'b0, 6'h3F, 8'h00);
    `CHK(rdat, 8'h00)
    // each control bit alone except the training bit 0
    for (int b = 1; b < 8; b++) begin
      v = 8'h01 << b;
      xfer(1'b1, `SPDQ_ADDR_SPC, v);
      tick(2);
      `CHK(flags, {v[7], v[6], v[5], v[3], v[1], v[0]})
      `CHK(masked_ok, !v[5])
      `CHK(mon_en, v[2])
    end
    // random codes into alternating write copies; first two hit the last valid and first reserved code
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, `SPDQ_ADDR_SPC, {1'b0, i[0], 6'h00});
      d = 8'($random(seed));
      if (i < 2) d[5:0] = i[0] ? 6'h33 : `SPDQ_DQR_CODE_MAX;
      xfer(1'b1, `SPDQ_ADDR_DQR, d);
      if (d[5:0] <= `SPDQ_DQR_CODE_MAX) cp[i[0]] = {d[6], d[5:0]};
      xfer(1'b0, `SPDQ_ADDR_DQR, 8'h00);
      `CHK(rdat, {1'b0, cp[i[0]]})
    end
    // operating copy with monitor on while the other copy is rewritten
    for (int os = 0; os < 2; os++) begin
      xfer(1'b1, `SPDQ_ADDR_SPC, {os[0], !os[0], 6'h04});
      d = 8'($random(seed));
      d[5] = 1'b0;
      xfer(1'b1, `SPDQ_ADDR_DQR, d);
      cp[!os[0]] = {d[6], d[5:0]};
      tick(2);
      `CHK(dq_active, cp[os])
      `CHK(mon_dq1, cp[os])
      `CHK(mon_dq0, ca_vref)
    end
    // refresh status filter over option, feature bit and every raw code
    for (int o = 0; o < 2; o++) begin
      xfer(1'b1, `SPDQ_ADDR_SPC, {3'h0, o[0], 4'h0});
      for (int k = 0; k < 16; k++) begin
        feat_opt <= k[3];
        refresh_raw <= k[2:0];
        tick(3);
        `CHK(refresh_status, exp_refresh(k[2:0], o[0], k[3]))
        `CHK(refresh_mode, exp_refresh(k[2:0], o[0], k[3]))
      end
    end
    // training: echo of ca while cke is low, then leave through a clearing write
    xfer(1'b1, `SPDQ_ADDR_SPC, 8'h01);
    tick(2);
    `CHK(cmd_train, 1'b1)
    cke_low <= 1'b1;
    tick(4);
    for (int t = 0; t < 4; t++) begin
      train_ca <= 6'($random(seed));
      tick(3);
      `CHK(lnk.dq, {2'h0, train_ca})
      `CHK(lnk.dq_oe, 1'b1)
    end
    cke_low <= 1'b0;
    xfer(1'b1, `SPDQ_ADDR_SPC, 8'h00);
    tick(2);
    `CHK(cmd_train, 1'b0)
    // reset in mid-run brings back defaults
    do_reset();
    xfer(1'b0, `SPDQ_ADDR_DQR, 8'h00);
    `CHK(rdat, 8'h4D)
    `CHK(flags, 6'h00)
    stop_test();
  end
endmodule : set_point_and_dq_vref_mode_regs_bench
